// [sqcfg_pkg.sv]
package sqcfg_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  STEP14_CFG_ADDR   = 8'h9e;
	localparam logic [9:0]  STEP14_BYTE_ADDR  = 10'h278;
	localparam logic [15:0] STEP14_CFG_RESET  = 16'h000e;
	localparam logic [15:0] STEP14_WRITE_MASK = 16'he01f;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ACTIVE_BIT   = 15;
	localparam int GAIN_HI      = 14;
	localparam int GAIN_LO      = 13;
	localparam int NEG_BIT      = 4;
	localparam int POS_HI       = 3;
	localparam int POS_LO       = 0;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
	localparam logic [1:0] GAIN_CODE_X2 = 2'h1;

	typedef enum logic [2:0] {
		SQCFG_GAIN_X1 = 3'h1,
		SQCFG_GAIN_X2 = 3'h2,
		SQCFG_GAIN_X4 = 3'h4
	} sqcfg_gain_type;

	typedef enum logic [1:0] {
		SQCFG_NEG_GROUND = 2'h0,
		SQCFG_NEG_INPUT7 = 2'h1,
		SQCFG_NEG_AUTO   = 2'h2
	} sqcfg_neg_type;

	localparam logic [3:0] POS_TEMP_SENSOR = 4'h8;
	localparam logic [3:0] POS_SHORT       = 4'h9;
	localparam logic [3:0] POS_TEST_DAC    = 4'ha;
	localparam logic [3:0] POS_ANALOG_DIV4 = 4'hb;
	localparam logic [3:0] POS_IO_DIV4     = 4'hc;
	localparam logic [3:0] POS_DIG_DIV4    = 4'hd;
	localparam logic [3:0] POS_ANALOG_POWER  = 4'he;
	localparam logic [3:0] POS_DIGITAL_POWER = 4'hf;

	// Source one-hot: bits 0..7 external, 8..15 internal
	localparam int SOURCE_COUNT = 16;

endpackage

// [sqcfg_cfg_if.sv]
`timescale 1ns/1ns
interface sqcfg_cfg_if;
	logic [15:0] cfg;
	modport store (output cfg);
	modport route (input cfg);
endinterface

// [sqcfg_store.sv]
`timescale 1ns/1ns
module sqcfg_store
	import sqcfg_pkg::*;
(
	input  wire logic        mclk,     // System clock
	input  wire logic        resetn,   // Synchronous reset, active low
	input  wire logic        wr_en,    // One-cycle write strobe
	input  wire logic [15:0] wr_data,  // Write data
	input  wire logic [1:0]  wr_lanes, // Byte lanes to update
	sqcfg_cfg_if.store       cfg_out   // Stored register
);

	logic [15:0] lane_mask;

	assign lane_mask = {{8{wr_lanes[1]}}, {8{wr_lanes[0]}}} & STEP14_WRITE_MASK;

	// Reserved bits 12:5 never load, so they stay zero after reset
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cfg_out.cfg <= STEP14_CFG_RESET;
		end else if (wr_en) begin
			cfg_out.cfg <= (cfg_out.cfg & ~lane_mask) | (wr_data & lane_mask);
		end
	end

endmodule

// [sqcfg_route.sv]
`timescale 1ns/1ns
module sqcfg_route
	import sqcfg_pkg::*;
(
	input  wire logic                    mclk,     // System clock
	input  wire logic                    resetn,   // Synchronous reset, active low
	sqcfg_cfg_if.route                   cfg_in,   // Stored register
	output logic                         active,   // Step included
	output sqcfg_gain_type               gain,     // Gain one-hot
	output sqcfg_neg_type                neg_sel,  // Negative routing
	output logic [SOURCE_COUNT-1:0]      pos_sel   // Positive source one-hot
);

	logic [3:0] pos_code;

	assign pos_code = cfg_in.cfg[POS_HI:POS_LO];

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			active <= 1'b0;
		end else begin
			active <= cfg_in.cfg[ACTIVE_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			gain <= SQCFG_GAIN_X1;
		end else begin
			unique case (cfg_in.cfg[GAIN_HI:GAIN_LO])
				GAIN_CODE_X1: gain <= SQCFG_GAIN_X1;
				GAIN_CODE_X2: gain <= SQCFG_GAIN_X2;
				default:      gain <= SQCFG_GAIN_X4;
			endcase
		end
	end

	// Internal sources have the top code bit set and pick their own return
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			neg_sel <= SQCFG_NEG_AUTO;
		end else if (pos_code[3]) begin
			neg_sel <= SQCFG_NEG_AUTO;
		end else if (cfg_in.cfg[NEG_BIT]) begin
			neg_sel <= SQCFG_NEG_INPUT7;
		end else begin
			neg_sel <= SQCFG_NEG_GROUND;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pos_sel <= '0;
		end else begin
			pos_sel <= SOURCE_COUNT'(1) << pos_code;
		end
	end

	chk_auto_neg_forced: assert property (
		@(posedge mclk) disable iff (!resetn)
		cfg_in.cfg[POS_HI] |=> neg_sel == SQCFG_NEG_AUTO)
		else $error("internal source did not force automatic negative input");

	chk_neg_follows_bit: assert property (
		@(posedge mclk) disable iff (!resetn)
		!cfg_in.cfg[POS_HI] && cfg_in.cfg[NEG_BIT] |=> neg_sel == SQCFG_NEG_INPUT7)
		else $error("negative input not routed to input seven");

	// Sampled reset gates the start: the edge of release still loads reset values
	chk_pos_onehot: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn |=> pos_sel == (SOURCE_COUNT'(1) << $past(pos_code)))
		else $error("positive source does not match code");

	chk_gain_four: assert property (
		@(posedge mclk) disable iff (!resetn)
		cfg_in.cfg[GAIN_HI] |=> gain == SQCFG_GAIN_X4)
		else $error("gain codes 10 and 11 must give gain four");

	chk_temp_source: assert property (
		@(posedge mclk) disable iff (!resetn)
		pos_code == POS_TEMP_SENSOR |=> pos_sel[POS_TEMP_SENSOR] && neg_sel == SQCFG_NEG_AUTO)
		else $error("temperature sensor code not routed");

endmodule

// [sqcfg_step14.sv]
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
module sqcfg_step14
	import sqcfg_pkg::*;
(
	input  wire logic                    mclk,           // System clock, 50 MHz
	input  wire logic                    resetn,         // Synchronous reset, active low
	input  wire logic                    psel,           // APB select
	input  wire logic                    penable,        // APB access phase
	input  wire logic                    pwrite,         // APB write
	input  wire logic [11:0]             paddr,          // APB byte address
	input  wire logic [31:0]             pwdata,         // APB write data
	input  wire logic [3:0]              pstrb,          // APB byte strobes
	output logic                         pready,         // APB ready
	output logic [31:0]                  prdata,         // APB read data
	output logic                         pslverr,        // APB error on unmapped address
	output logic                         step14_active,  // Step in sequence
	output sqcfg_gain_type               step14_amplification, // Gain one-hot
	output sqcfg_neg_type                step14_negative_select, // Negative routing
	output logic [SOURCE_COUNT-1:0]      step14_positive_select  // Positive one-hot
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic        setup;
	logic        hit;
	logic        wr_en;
	logic [15:0] cfg_view;
	logic [3:0]  pos_view;

	sqcfg_cfg_if cfg_bus ();

	// One wait state: ready is registered at the end of the first access cycle, so every
	// transfer completes in the second access-phase cycle.
	assign setup = psel && penable && !pready;
	assign hit   = (paddr == {2'h0, STEP14_BYTE_ADDR});
	assign wr_en = setup && pwrite && hit;
	assign cfg_view = cfg_bus.cfg;
	assign pos_view = cfg_view[POS_HI:POS_LO];

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup && !hit;
		end
	end

	// Reserved bits are held at zero in storage, so reads return zero there
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prdata <= '0;
		end else if (setup && !pwrite && hit) begin
			prdata <= {16'h0000, cfg_view};
		end else begin
			prdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// Storage and routing
	// ------------------------------------------------------------
	sqcfg_store u_store (
		.mclk     (mclk),
		.resetn   (resetn),
		.wr_en    (wr_en),
		.wr_data  (pwdata[15:0]),
		.wr_lanes (pstrb[1:0]),
		.cfg_out  (cfg_bus)
	);

	sqcfg_route u_route (
		.mclk     (mclk),
		.resetn   (resetn),
		.cfg_in   (cfg_bus),
		.active   (step14_active),
		.gain     (step14_amplification),
		.neg_sel  (step14_negative_select),
		.pos_sel  (step14_positive_select)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_reserved_zero: assert property (
		@(posedge mclk) disable iff (!resetn)
		cfg_view[GAIN_LO-1:NEG_BIT+1] == '0)
		else $error("reserved bits not zero");

	chk_write_lands: assert property (
		@(posedge mclk) disable iff (!resetn)
		wr_en && (&pstrb[1:0]) |=> cfg_view == ($past(pwdata[15:0]) & STEP14_WRITE_MASK))
		else $error("write to step register did not land");

	chk_active_follows: assert property (
		@(posedge mclk) disable iff (!resetn)
		wr_en && pstrb[1] |=> ##1 step14_active == $past(pwdata[ACTIVE_BIT], 2))
		else $error("step enable output does not follow bit 15");

	chk_read_ready: assert property (
		@(posedge mclk) disable iff (!resetn)
		setup |=> pready ##1 !pready)
		else $error("ready not a single cycle after access");

	// ------------------------------------------------------------
	// Reset checks
	// ------------------------------------------------------------
	chk_reset_cfg_value: assert property (
		@(posedge mclk)
		!resetn |=> cfg_view == STEP14_CFG_RESET)
		else $error("register not at reset value after reset");

	chk_reset_active_off: assert property (
		@(posedge mclk)
		!resetn |=> !step14_active)
		else $error("step enable output set during reset");

	chk_reset_gain_one: assert property (
		@(posedge mclk)
		!resetn |=> step14_amplification == SQCFG_GAIN_X1)
		else $error("gain output not one during reset");

	chk_reset_neg_auto: assert property (
		@(posedge mclk)
		!resetn |=> step14_negative_select == SQCFG_NEG_AUTO)
		else $error("negative routing not automatic during reset");

	chk_reset_pos_clear: assert property (
		@(posedge mclk)
		!resetn |=> step14_positive_select == '0)
		else $error("positive routing not clear during reset");

	chk_reset_bus_idle: assert property (
		@(posedge mclk)
		!resetn |=> !pready && !pslverr && prdata == 32'h0000_0000)
		else $error("bus outputs not idle during reset");

	// ------------------------------------------------------------
	// Bus checks
	// ------------------------------------------------------------
	chk_ready_one_cycle: assert property (
		@(posedge mclk) disable iff (!resetn)
		pready |=> !pready)
		else $error("ready held for more than one cycle");

	chk_ready_after_setup: assert property (
		@(posedge mclk) disable iff (!resetn)
		pready |-> $past(setup))
		else $error("ready without a preceding access cycle");

	chk_idle_no_ready: assert property (
		@(posedge mclk) disable iff (!resetn)
		!psel |=> !pready)
		else $error("ready raised while not selected");

	chk_err_with_ready: assert property (
		@(posedge mclk) disable iff (!resetn)
		pslverr |-> pready)
		else $error("error response without ready");

	chk_rdata_idle_zero: assert property (
		@(posedge mclk) disable iff (!resetn)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data not zero outside a response");

	chk_read_returns_cfg: assert property (
		@(posedge mclk) disable iff (!resetn)
		setup && !pwrite && hit |=> prdata == {16'h0000, $past(cfg_view)})
		else $error("read data does not match register");

	chk_err_unmapped: assert property (
		@(posedge mclk) disable iff (!resetn)
		setup && !hit |=> pslverr)
		else $error("unmapped access without error response");

	chk_no_err_mapped: assert property (
		@(posedge mclk) disable iff (!resetn)
		setup && hit |=> !pslverr)
		else $error("error response on the step register");

	chk_unmapped_no_write: assert property (
		@(posedge mclk) disable iff (!resetn)
		setup && pwrite && !hit |=> $stable(cfg_view))
		else $error("unmapped write changed the register");

	chk_no_lane_no_write: assert property (
		@(posedge mclk) disable iff (!resetn)
		wr_en && pstrb[1:0] == 2'h0 |=> $stable(cfg_view))
		else $error("write without strobes changed the register");

	chk_low_lane_keeps: assert property (
		@(posedge mclk) disable iff (!resetn)
		wr_en && !pstrb[1] |=> cfg_view[15:8] == $past(cfg_view[15:8]))
		else $error("upper byte changed without its strobe");

	chk_high_lane_keeps: assert property (
		@(posedge mclk) disable iff (!resetn)
		wr_en && !pstrb[0] |=> cfg_view[7:0] == $past(cfg_view[7:0]))
		else $error("lower byte changed without its strobe");

	chk_idle_cfg_holds: assert property (
		@(posedge mclk) disable iff (!resetn)
		!wr_en |=> $stable(cfg_view))
		else $error("register changed without a write");

	chk_setup_no_write: assert property (
		@(posedge mclk) disable iff (!resetn)
		psel && !penable |=> $stable(cfg_view))
		else $error("register written in the setup cycle");

	// ------------------------------------------------------------
	// Routing checks
	// ------------------------------------------------------------
	chk_active_set: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && cfg_view[ACTIVE_BIT] |=> step14_active)
		else $error("step not included with bit 15 set");

	chk_active_clear: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && !cfg_view[ACTIVE_BIT] |=> !step14_active)
		else $error("step included with bit 15 clear");

	chk_gain_code_one: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && cfg_view[GAIN_HI:GAIN_LO] == GAIN_CODE_X1 |=> step14_amplification == SQCFG_GAIN_X1)
		else $error("gain code 00 not gain one");

	chk_gain_code_two: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && cfg_view[GAIN_HI:GAIN_LO] == GAIN_CODE_X2 |=> step14_amplification == SQCFG_GAIN_X2)
		else $error("gain code 01 not gain two");

	chk_gain_code_four: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && cfg_view[GAIN_HI] |=> step14_amplification == SQCFG_GAIN_X4)
		else $error("gain codes 10 and 11 not gain four");

	chk_neg_ground_ref: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && !cfg_view[POS_HI] && !cfg_view[NEG_BIT] |=> step14_negative_select == SQCFG_NEG_GROUND)
		else $error("negative input not on ground reference");

	chk_neg_input_seven: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && !cfg_view[POS_HI] && cfg_view[NEG_BIT] |=> step14_negative_select == SQCFG_NEG_INPUT7)
		else $error("negative input not on input seven");

	chk_neg_auto_low: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && cfg_view[POS_HI] && !cfg_view[NEG_BIT] |=> step14_negative_select == SQCFG_NEG_AUTO)
		else $error("internal source without automatic negative input");

	chk_neg_auto_high: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && cfg_view[POS_HI] && cfg_view[NEG_BIT] |=> step14_negative_select == SQCFG_NEG_AUTO)
		else $error("negative select bit not ignored for internal source");

	chk_pos_one_hot: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn |=> $onehot(step14_positive_select))
		else $error("positive routing not one-hot");

	chk_pos_exact_map: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn |=> step14_positive_select == (SOURCE_COUNT'(1) << $past(pos_view)))
		else $error("positive routing does not match code");

	chk_pos_temp_sensor: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_TEMP_SENSOR |=> step14_positive_select[POS_TEMP_SENSOR])
		else $error("temperature sensor not selected");

	chk_pos_internal_short: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_SHORT |=> step14_positive_select[POS_SHORT])
		else $error("internal short not selected");

	chk_pos_test_dac: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_TEST_DAC |=> step14_positive_select[POS_TEST_DAC])
		else $error("test source not selected");

	chk_pos_analog_quarter: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_ANALOG_DIV4 |=> step14_positive_select[POS_ANALOG_DIV4])
		else $error("analog supply monitor not selected");

	chk_pos_io_quarter: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_IO_DIV4 |=> step14_positive_select[POS_IO_DIV4])
		else $error("io supply monitor not selected");

	chk_pos_digital_quarter: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_DIG_DIV4 |=> step14_positive_select[POS_DIG_DIV4])
		else $error("digital supply monitor not selected");

	chk_pos_analog_power: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_ANALOG_POWER |=> step14_positive_select[POS_ANALOG_POWER])
		else $error("analog power monitor not selected");

	chk_pos_digital_power: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn && pos_view == POS_DIGITAL_POWER |=> step14_positive_select[POS_DIGITAL_POWER])
		else $error("digital power monitor not selected");

endmodule

// [sqcfg_step14_tb_top.sv]
`timescale 1ns/1ns
module sqcfg_step14_tb_top
	import sqcfg_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus and design
	// ------------------------------------------------------------
	localparam logic [11:0] REG_ADDR = {2'h0, STEP14_CFG_ADDR, 2'h0};

	logic                    mclk    = 1'b0;
	logic                    resetn  = 1'b0;
	logic                    psel    = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite  = 1'b0;
	logic [11:0]             paddr   = 12'h000;
	logic [31:0]             pwdata  = 32'h0000_0000;
	logic [3:0]              pstrb   = 4'h0;
	logic                    pready;
	logic [31:0]             prdata;
	logic                    pslverr;
	logic                    active;
	sqcfg_gain_type          gain;
	sqcfg_neg_type           neg;
	logic [SOURCE_COUNT-1:0] pos;
	int                      miscompares = 0;
	int                      tests_run = 0;

	always #10 mclk = ~mclk;

	sqcfg_step14 u_sqcfg_step14 (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .step14_active(active),
		.step14_amplification(gain), .step14_negative_select(neg),
		.step14_positive_select(pos));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	// Ends one edge after release so a following setup never reassigns psel in one step
	task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		// No local limit: only the watchdog ends a wait for ready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_route(input logic [15:0] r);
		sqcfg_gain_type g;
		sqcfg_neg_type  n;
		g = (r[14:13] == GAIN_CODE_X1) ? SQCFG_GAIN_X1 :
			(r[14:13] == GAIN_CODE_X2) ? SQCFG_GAIN_X2 : SQCFG_GAIN_X4;
		n = r[3] ? SQCFG_NEG_AUTO : (r[4] ? SQCFG_NEG_INPUT7 : SQCFG_NEG_GROUND);
		#1;
		cmp({31'h0, active}, {31'h0, r[15]});
		cmp({29'h0, gain}, {29'h0, g});
		cmp({30'h0, neg}, {30'h0, n});
		cmp({16'h0, pos}, {16'h0, 16'h0001 << r[3:0]});
		@(posedge mclk);
	endtask

	task automatic wr_rd(input logic [15:0] d, input logic [3:0] s, output logic [31:0] rd);
		logic e;
		apb(REG_ADDR, 1'b1, d, s, rd, e);
		apb(REG_ADDR, 1'b0, 16'h0000, 4'h0, rd, e);
		cmp({31'h0, e}, 32'h0);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] rd;
		wr_rd(16'hffff, 4'h3, rd);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		wr_rd(16'h000e, 4'h0, rd);
		cmp(rd, {16'h0, STEP14_CFG_RESET});
		cmp_route(16'h000e);
	endtask

	task automatic t_fields();
		logic [31:0] rd;
		wr_rd(16'hffff, 4'hf, rd);
		cmp(rd, 32'h0000_e01f);
		cmp_route(16'he01f);
		wr_rd(16'h0000, 4'h2, rd);
		cmp(rd, 32'h0000_001f);
		wr_rd(16'h6011, 4'h1, rd);
		cmp(rd, 32'h0000_0011);
		cmp_route(16'h0011);
	endtask

	task automatic t_gain();
		logic [31:0] rd;
		logic [15:0] v;
		for (int g = 0; g < 4; g++) begin
			v = {1'b1, 2'(g), 8'h00, 1'b1, 4'h3};
			wr_rd(v, 4'h3, rd);
			cmp(rd, {16'h0, v});
			cmp_route(v);
		end
	endtask

	task automatic t_pos();
		logic [31:0] rd;
		logic [15:0] v;
		for (int p = 0; p < 16; p++) begin
			for (int n = 0; n < 2; n++) begin
				v = {1'b0, 2'h1, 8'h00, 1'(n), 4'(p)};
				wr_rd(v, 4'h3, rd);
				cmp_route(v);
			end
		end
	endtask

	task automatic t_unmapped();
		logic [31:0] rd;
		logic        e;
		apb(REG_ADDR + 12'h004, 1'b1, 16'h8000, 4'h3, rd, e);
		cmp({31'h0, e}, 32'h1);
		apb(REG_ADDR + 12'h004, 1'b0, 16'h0000, 4'h0, rd, e);
		cmp({31'h0, e}, 32'h1);
		cmp(rd, 32'h0);
		wr_rd(16'h0000, 4'h0, rd);
		cmp(rd, 32'h0000_201f);
	endtask

	task automatic finish_test();
		if (miscompares == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_fields();
		t_gain();
		t_pos();
		t_unmapped();
		finish_test();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#100000;
		miscompares++;
		finish_test();
	end
endmodule
